// >>> sbtc_timer.sv
// Sixteen-bit timer/counter with APB register access
//
// Summary of operation
// - Sixteen-bit count in two bytes, wraps to zero
// - Wrap sets overflow flag; interrupt only if enabled
// - Source select: external pin edges or instruction clock
// - Run enable advances count, clear freezes it
// - Prescale field divides input by 1, 2, 4, 8
// - Oscillator enable forces pins input, reads zero
// - Sync select honoured only in external mode
// - Falling edge needed before first counted rising edge
// - Oscillator enable picks oscillator pin as source
// - Prescaler precedes the synchroniser
// - Synchronised mode stops counting in sleep
// - Unsynchronised mode counts in sleep, may wake
// - No compare time-base in unsynchronised mode
// - Byte reads of a running count are not latched together and can tear
// - Special event trigger with code 1011 clears count
// - Trigger clear only in timer or synchronised mode
// - Count write wins over coinciding trigger clear
// - Count bytes untouched by any reset
// - Control register clears to zero on reset
// - Any count byte write clears the prescaler
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module sbtc_timer
    import sbtc_pkg::*;
#(
    parameter int INSTR_DIV = SBTC_INSTR_DIV
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_clock_pin,
    input  wire logic        osc_input_pin,
    input  wire logic        sleep_mode,
    input  wire logic [3:0]  compare_mode_field,
    input  wire logic        compare_trigger,
    input  wire logic [1:0]  port_direction,
    output logic      [1:0]  port_pin_oe,
    output logic      [1:0]  port_read_data,
    output logic             osc_drive_enable,
    output logic             overflow_irq,
    output logic             wake_request,
    output logic      [15:0] count_timebase,
    output logic             timebase_valid
);

    // Width of the instruction-clock divider, never below one bit
    localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;

    // Address match on a word-aligned register offset
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr[7:2] == off[7:2]);
    endfunction : reg_hit

    // Registers
    logic [7:0]       timer_control;
    logic [15:0]      count;
    logic             overflow_flag;
    logic             overflow_irq_enable;
    logic [DIV_W-1:0] div_cnt;
    logic             ext_prev;
    logic             armed;
    logic             sync_q1;
    logic             sync_q2;
    logic             sync_q3;

    // Control fields
    logic       run_enable;
    logic       clock_source_select;
    logic       sync_disable;
    logic       osc_enable;
    logic [1:0] prescale_select;

    assign run_enable          = timer_control[SBTC_CTL_RUN_BIT];
    assign clock_source_select = timer_control[SBTC_CTL_CS_BIT];
    assign sync_disable        = timer_control[SBTC_CTL_SYNC_DIS_BIT];
    assign osc_enable          = timer_control[SBTC_CTL_OSC_EN_BIT];
    assign prescale_select     = timer_control[SBTC_CTL_PS_MSB:SBTC_CTL_PS_LSB];

    // Mode decode: sync select only matters with the external source
    logic ext_mode;
    logic async_mode;
    logic sync_mode;

    assign ext_mode   = clock_source_select;
    assign async_mode = ext_mode & sync_disable;
    assign sync_mode  = ext_mode & ~sync_disable;

    // APB decode
    logic setup_phase;
    logic access_wr;
    logic hit_low;
    logic hit_high;
    logic hit_flag;
    logic hit_irq_en;
    logic hit_control;
    logic hit_status;
    logic addr_mapped;

    assign setup_phase = psel & ~penable;
    assign access_wr   = psel & penable & pwrite;
    assign hit_low     = reg_hit(paddr, SBTC_OFF_COUNT_LOW);
    assign hit_high    = reg_hit(paddr, SBTC_OFF_COUNT_HIGH);
    assign hit_flag    = reg_hit(paddr, SBTC_OFF_FLAG);
    assign hit_irq_en  = reg_hit(paddr, SBTC_OFF_IRQ_EN);
    assign hit_control = reg_hit(paddr, SBTC_OFF_CONTROL);
    assign hit_status  = reg_hit(paddr, SBTC_OFF_STATUS);
    assign addr_mapped = hit_low | hit_high | hit_flag | hit_irq_en | hit_control | hit_status;

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_mapped;

    // Write strobes per register
    logic wr_low;
    logic wr_high;
    logic wr_count;
    logic wr_flag;
    logic wr_irq_en;
    logic wr_control;

    assign wr_low     = access_wr & hit_low;
    assign wr_high    = access_wr & hit_high;
    assign wr_count   = wr_low | wr_high;
    assign wr_flag    = access_wr & hit_flag;
    assign wr_irq_en  = access_wr & hit_irq_en;
    assign wr_control = access_wr & hit_control;

    // Instruction clock enable, one pulse every INSTR_DIV clocks
    logic instr_tick;

    assign instr_tick = (div_cnt == DIV_W'(INSTR_DIV - 1));

    // Free-running divider that paces the instruction tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= instr_tick ? '0 : div_cnt + 1'b1;
        end
    end

    // External input choice and edge detection
    logic ext_in;
    logic ext_rise;
    logic ext_fall;

    assign ext_in   = osc_enable ? osc_input_pin : ext_clock_pin;
    assign ext_rise = ext_in & ~ext_prev;
    assign ext_fall = ~ext_in & ext_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_in;
        end
    end

    // Arming: a falling edge must be seen after enabling external mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed <= 1'b0;
        end else if (!ext_mode || !run_enable) begin
            armed <= 1'b0;
        end else if (ext_fall) begin
            armed <= 1'b1;
        end
    end

    // Prescaler input: armed external rising edges or instruction ticks
    logic pre_in_tick;
    logic pre_tick;
    logic pre_level;

    assign pre_in_tick = run_enable
                       & (ext_mode ? (ext_rise & armed)
                                   : (instr_tick & ~sleep_mode));

    // Prescaler sits ahead of any synchronisation
    sbtc_prescaler #(
        .STAGES (3)
    ) u_prescaler (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_tick   (pre_in_tick),
        .clear     (wr_count),
        .sel       (prescale_select),
        .out_tick  (pre_tick),
        .out_level (pre_level)
    );

    // Two-stage synchroniser on the prescaler output, then edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q1 <= 1'b0;
            sync_q2 <= 1'b0;
            sync_q3 <= 1'b0;
        end else begin
            sync_q1 <= pre_level;
            sync_q2 <= sync_q1;
            sync_q3 <= sync_q2;
        end
    end

    // Rising edge of the synchronised prescaler pulse
    logic sync_rise;

    assign sync_rise = sync_q2 & ~sync_q3;

    // Increment request per mode; the synchroniser is off in sleep
    logic inc;

    assign inc = run_enable
               & (sync_mode  ? (sync_rise & ~sleep_mode)
               :  async_mode ? pre_tick
               :               pre_tick);

    // Special event clear, not honoured in unsynchronised mode
    logic trig_clear;

    assign trig_clear = compare_trigger
                      & (compare_mode_field == SBTC_CMP_SPECIAL)
                      & ~async_mode;

    // Wrap detection on an increment that actually lands
    logic overflow_event;

    assign overflow_event = inc & ~wr_count & ~trig_clear
                          & (count == SBTC_COUNT_MAX);

    // Count bytes: no reset term, writes win over trigger and increment
    always_ff @(posedge pclk) begin
        if (wr_count) begin
            if (wr_low) begin
                count[7:0] <= pwdata[7:0];
            end
            if (wr_high) begin
                count[15:8] <= pwdata[7:0];
            end
        end else if (trig_clear) begin
            count <= '0;
        end else if (inc) begin
            count <= count + 16'h0001;
        end
    end

    // Control register, cleared at reset which stops the timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control <= SBTC_CTL_RESET;
        end else if (wr_control) begin
            timer_control <= pwdata[7:0] & SBTC_CTL_MASK;
        end
    end

    // Overflow flag: hardware set wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag <= 1'b0;
        end else if (overflow_event) begin
            overflow_flag <= 1'b1;
        end else if (wr_flag) begin
            overflow_flag <= pwdata[0];
        end
    end

    // Overflow interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_irq_enable <= 1'b0;
        end else if (wr_irq_en) begin
            overflow_irq_enable <= pwdata[0];
        end
    end

    // Interrupt request and wake from sleep
    assign overflow_irq = overflow_flag & overflow_irq_enable;
    assign wake_request = overflow_irq & sleep_mode & async_mode;

    // Read multiplexer
    logic [31:0] rd_mux;
    logic [7:0]  status_byte;

    // Status byte: unsynchronised mode and armed state
    assign status_byte = {6'h0, async_mode, armed};
    assign rd_mux = hit_low     ? {24'h000000, count[7:0]}
                  : hit_high    ? {24'h000000, count[15:8]}
                  : hit_flag    ? {31'h0, overflow_flag}
                  : hit_irq_en  ? {31'h0, overflow_irq_enable}
                  : hit_control ? {24'h000000, timer_control}
                  : hit_status  ? {24'h000000, status_byte}
                  :               32'h00000000;

    // Read data captured in the setup phase and held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_phase && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Port pins: oscillator enable forces both pins to inputs reading zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_pin_oe      <= 2'b00;
            port_read_data   <= 2'b00;
            osc_drive_enable <= 1'b0;
        end else begin
            port_pin_oe      <= osc_enable ? 2'b00 : ~port_direction;
            port_read_data   <= osc_enable ? 2'b00
                                           : {osc_input_pin, ext_clock_pin};
            osc_drive_enable <= osc_enable;
        end
    end

    // Time-base for capture and compare, withheld in unsynchronised mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_timebase <= 16'h0000;
            timebase_valid <= 1'b0;
        end else begin
            count_timebase <= async_mode ? 16'h0000 : count;
            timebase_valid <= ~async_mode;
        end
    end

endmodule : sbtc_timer

// >>> sbtc_pkg.sv
// Constants shared by the sixteen-bit timer/counter block
package sbtc_pkg;

    // Register byte offsets on the APB word map
    localparam logic [7:0] SBTC_OFF_COUNT_LOW  = 8'h00;
    localparam logic [7:0] SBTC_OFF_COUNT_HIGH = 8'h04;
    localparam logic [7:0] SBTC_OFF_FLAG       = 8'h08;
    localparam logic [7:0] SBTC_OFF_IRQ_EN     = 8'h0c;
    localparam logic [7:0] SBTC_OFF_CONTROL    = 8'h10;
    localparam logic [7:0] SBTC_OFF_STATUS     = 8'h14;

    // Field positions in timer_control
    localparam int SBTC_CTL_RUN_BIT      = 0;
    localparam int SBTC_CTL_CS_BIT       = 1;
    localparam int SBTC_CTL_SYNC_DIS_BIT = 2;
    localparam int SBTC_CTL_OSC_EN_BIT   = 3;
    localparam int SBTC_CTL_PS_LSB       = 4;
    localparam int SBTC_CTL_PS_MSB       = 5;

    // Writable bits of timer_control; bits 7:6 read as zero
    localparam logic [7:0] SBTC_CTL_MASK  = 8'h3f;
    localparam logic [7:0] SBTC_CTL_RESET = 8'h00;

    // Field positions in the status word
    localparam int SBTC_STA_ARMED_BIT = 0;
    localparam int SBTC_STA_ASYNC_BIT = 1;

    // Compare mode code that requests the special event reset
    localparam logic [3:0] SBTC_CMP_SPECIAL = 4'hb;

    // Internal instruction clock is the oscillator clock divided by four
    localparam int SBTC_INSTR_DIV = 4;

    // Count value at which the next increment wraps
    localparam logic [15:0] SBTC_COUNT_MAX = 16'hffff;

endpackage : sbtc_pkg

// >>> sbtc_prescaler.sv
// Three-stage binary prescaler selecting 1:1, 1:2, 1:4 or 1:8
`timescale 1ns/1ps
module sbtc_prescaler
    import sbtc_pkg::*;
#(
    parameter int STAGES = 3
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       in_tick,
    input  wire logic       clear,
    input  wire logic [1:0] sel,
    output logic            out_tick,
    output logic            out_level
);

    logic [STAGES-1:0] stage;
    logic [STAGES-1:0] tap_mask;
    logic              wrap;

    // Mask of stages that must all be one before an output tick
    assign tap_mask = STAGES'((1 << sel) - 1);
    assign wrap     = ((stage & tap_mask) == tap_mask);
    assign out_tick = in_tick & wrap;

    // Stage counter, cleared by any count write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= '0;
        end else if (clear) begin
            stage <= '0;
        end else if (in_tick) begin
            stage <= wrap ? '0 : stage + 1'b1;
        end
    end

    // Registered copy of the output tick for the synchronising path
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_level <= 1'b0;
        end else begin
            out_level <= out_tick & ~clear;
        end
    end

endmodule : sbtc_prescaler

// >>> sbtc_clk_src.sv
// Model of the external count source feeding the timer pins
`timescale 1ns/1ps
module sbtc_clk_src (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic go,
    input  wire logic use_osc,
    output logic      ext_clock_pin,
    output logic      osc_input_pin
);
    logic [1:0] phase;
    logic       level;

    // Three cycles high, three low, parked low outside a burst
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 2'd0;
            level <= 1'b0;
        end else if (!go || phase == 2'd2) begin
            phase <= 2'd0;
            level <= go && !level;
        end else begin
            phase <= phase + 2'd1;
        end
    end

    // Only the chosen pin toggles, the other stays quiet
    assign ext_clock_pin = level && !use_osc;
    assign osc_input_pin = level && use_osc;
endmodule : sbtc_clk_src

// >>> sbtc_timer_assertions.sv
// Port-level checks for the timer/counter, bound to its top module
`timescale 1ns/1ps
module sbtc_timer_checker
    import sbtc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        ext_clock_pin,
    input wire logic        osc_input_pin,
    input wire logic        sleep_mode,
    input wire logic [3:0]  compare_mode_field,
    input wire logic        compare_trigger,
    input wire logic [1:0]  port_direction,
    input wire logic [1:0]  port_pin_oe,
    input wire logic [1:0]  port_read_data,
    input wire logic        osc_drive_enable,
    input wire logic        overflow_irq,
    input wire logic        wake_request,
    input wire logic [15:0] count_timebase,
    input wire logic        timebase_valid
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Decoded bus writes and trigger qualifier
    wire logic wr_acc  = psel && penable && pwrite;
    wire logic irq_wr  = wr_acc && paddr[7:3] == 5'h1;
    wire logic cnt_wr  = wr_acc && paddr[7:3] == 5'h0;
    wire logic low_wr  = wr_acc && paddr[7:2] == 6'h0;
    wire logic trig_ok = compare_trigger && compare_mode_field == SBTC_CMP_SPECIAL
                         && timebase_valid;

    sequence s_trig_plain;
        trig_ok && !cnt_wr;
    endsequence
    sequence s_trig_write;
        trig_ok && low_wr;
    endsequence

    chk_osc_forces_in: assert property (
        osc_drive_enable |-> port_pin_oe == 2'b00 && port_read_data == 2'b00)
        else $error("oscillator pins not forced to input");
    chk_dir_follow: assert property (
        !osc_drive_enable && $past(presetn) |-> port_pin_oe == ~$past(port_direction))
        else $error("pin enable does not follow direction");
    chk_pin_readback: assert property (
        !osc_drive_enable && $past(presetn)
        |-> port_read_data == $past({osc_input_pin, ext_clock_pin}))
        else $error("pin read data wrong");
    chk_async_no_base: assert property (
        !timebase_valid |-> count_timebase == 16'h0000)
        else $error("time-base offered in async mode");
    chk_wake_cause: assert property (
        wake_request |-> overflow_irq && sleep_mode)
        else $error("wake without enabled overflow in sleep");
    chk_irq_drop: assert property (
        $fell(overflow_irq) |-> $past(irq_wr))
        else $error("interrupt dropped without software write");
    chk_ctl_reset: assert property (
        !$past(presetn) |=> timebase_valid && !osc_drive_enable)
        else $error("control not cleared by reset");
    chk_trig_clear: assert property (
        s_trig_plain |-> ##2 count_timebase == 16'h0000)
        else $error("trigger did not clear count");
    chk_write_wins: assert property (
        s_trig_write |-> ##2 count_timebase[7:0] == $past(pwdata[7:0], 2))
        else $error("trigger beat a count write");
endmodule : sbtc_timer_checker

bind sbtc_timer sbtc_timer_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .ext_clock_pin, .osc_input_pin, .sleep_mode, .compare_mode_field,
    .compare_trigger, .port_direction, .port_pin_oe, .port_read_data, .osc_drive_enable,
    .overflow_irq, .wake_request, .count_timebase, .timebase_valid);

// >>> testbench.sv
// Self-checking bench for the timer/counter block
`timescale 1ns/1ps
module testbench
    import sbtc_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, sleep_mode, compare_trigger;
    logic        go, use_osc, trig_acc, err, pready, pslverr, ext_clock_pin, osc_input_pin;
    logic        osc_drive_enable, overflow_irq, wake_request, timebase_valid;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  compare_mode_field;
    logic [1:0]  port_direction, port_pin_oe, port_read_data;
    logic [15:0] count_timebase;
    int          miscompares, n_checks, cycles;

    sbtc_timer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ext_clock_pin, .osc_input_pin, .sleep_mode, .compare_mode_field,
        .compare_trigger, .port_direction, .port_pin_oe, .port_read_data, .osc_drive_enable,
        .overflow_irq, .wake_request, .count_timebase, .timebase_valid);
    sbtc_clk_src u_src (.pclk, .presetn, .go, .use_osc, .ext_clock_pin, .osc_input_pin);

    always #10 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; trig_acc raises the trigger in the access cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        compare_trigger <= trig_acc;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        compare_trigger <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rdchk

    // Count is written only while stopped
    task automatic setcnt(input logic [15:0] v);
        wr(SBTC_OFF_COUNT_LOW, v[7:0]);
        wr(SBTC_OFF_COUNT_HIGH, v[15:8]);
    endtask : setcnt

    task automatic rd16(output logic [15:0] v);
        logic [7:0] h;
        do begin
            apb(1'b0, SBTC_OFF_COUNT_HIGH, 32'h0);
            h = q[7:0];
            apb(1'b0, SBTC_OFF_COUNT_LOW, 32'h0);
            v = {h, q[7:0]};
            apb(1'b0, SBTC_OFF_COUNT_HIGH, 32'h0);
        end while (q[7:0] !== h);
    endtask : rd16

    // Sixteen source pulses, then let the synchroniser settle
    task automatic pulses(input logic osc);
        use_osc <= osc;
        go      <= 1'b1;
        repeat (96) @(posedge pclk);
        go      <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : pulses

    task automatic trig();
        compare_trigger <= 1'b1;
        @(posedge pclk);
        compare_trigger <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : trig

    task automatic t_regs();
        rdchk(SBTC_OFF_CONTROL, 32'h0);
        wr(SBTC_OFF_CONTROL, 8'hfc);
        rdchk(SBTC_OFF_CONTROL, 32'h3c);
        setcnt(16'ha55a);
        rdchk(SBTC_OFF_COUNT_LOW, 32'h5a);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(q, 32'h0);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(SBTC_OFF_CONTROL, 32'h0);
        rdchk(SBTC_OFF_COUNT_HIGH, 32'ha5);
        $display("t_regs done");
    endtask : t_regs

    // Every prescale, sync and source-pin combination on external edges
    task automatic t_modes();
        logic [15:0] v;
        logic [3:0]  k;
        for (int i = 0; i < 16; i++) begin
            k = 4'(i);
            setcnt(16'h0000);
            wr(SBTC_OFF_CONTROL, {2'b00, k[1:0], k[3], k[2], 2'b11});
            repeat (k[3] ? 20 : 2) @(posedge pclk);
            chk({30'h0, port_pin_oe}, k[3] ? 32'h0 : {30'h0, ~port_direction});
            chk(32'(timebase_valid), 32'(!k[2]));
            pulses(k[3]);
            rd16(v);
            chk(32'(v), 32'(15 >> k[1:0]));
            wr(SBTC_OFF_CONTROL, 8'h00);
        end
        $display("t_modes done");
    endtask : t_modes

    task automatic t_over();
        logic [15:0] v, w;
        setcnt(16'hffff);
        wr(SBTC_OFF_FLAG, 8'h00);
        wr(SBTC_OFF_IRQ_EN, 8'h01);
        wr(SBTC_OFF_CONTROL, 8'h01);
        repeat (40) @(posedge pclk);
        wr(SBTC_OFF_CONTROL, 8'h00);
        rd16(v);
        chk(32'(v[15:8]), 32'h0);
        chk(32'(overflow_irq), 32'h1);
        repeat (40) @(posedge pclk);
        rd16(w);
        chk(32'(w), 32'(v));
        wr(SBTC_OFF_IRQ_EN, 8'h00);
        chk(32'(overflow_irq), 32'h0);
        rdchk(SBTC_OFF_FLAG, 32'h1);
        wr(SBTC_OFF_FLAG, 8'h00);
        rdchk(SBTC_OFF_FLAG, 32'h0);
        $display("t_over done");
    endtask : t_over

    task automatic t_sleep();
        logic [15:0] v;
        setcnt(16'h0010);
        sleep_mode <= 1'b1;
        wr(SBTC_OFF_CONTROL, 8'h03);
        pulses(1'b0);
        rd16(v);
        chk(32'(v), 32'h10);
        wr(SBTC_OFF_CONTROL, 8'h00);
        setcnt(16'hffff);
        wr(SBTC_OFF_IRQ_EN, 8'h01);
        wr(SBTC_OFF_CONTROL, 8'h07);
        pulses(1'b0);
        chk(32'(wake_request), 32'h1);
        rd16(v);
        chk(32'(v), 32'h0e);
        rdchk(SBTC_OFF_STATUS, 32'h3);
        sleep_mode <= 1'b0;
        wr(SBTC_OFF_CONTROL, 8'h00);
        $display("t_sleep done");
    endtask : t_sleep

    task automatic t_trig();
        compare_mode_field <= SBTC_CMP_SPECIAL;
        setcnt(16'h1280);
        wr(SBTC_OFF_CONTROL, 8'h01);
        trig();
        wr(SBTC_OFF_CONTROL, 8'h00);
        rdchk(SBTC_OFF_COUNT_HIGH, 32'h0);
        compare_mode_field <= 4'h0;
        setcnt(16'h1280);
        trig();
        rdchk(SBTC_OFF_COUNT_HIGH, 32'h12);
        compare_mode_field <= SBTC_CMP_SPECIAL;
        trig_acc = 1'b1;
        wr(SBTC_OFF_COUNT_LOW, 8'h5a);
        trig_acc = 1'b0;
        rdchk(SBTC_OFF_COUNT_LOW, 32'h5a);
        setcnt(16'h3344);
        wr(SBTC_OFF_CONTROL, 8'h07);
        trig();
        rdchk(SBTC_OFF_COUNT_HIGH, 32'h33);
        wr(SBTC_OFF_CONTROL, 8'h00);
        $display("t_trig done");
    endtask : t_trig

    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    // Cut a hang short
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end

    // Reset, then the scenarios in turn
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, sleep_mode, compare_trigger, go, use_osc, trig_acc} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        compare_mode_field = 4'h0;
        port_direction = 2'b10;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_modes();
        t_over();
        t_sleep();
        t_trig();
        final_report();
    end
endmodule : testbench
